// [aco_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "aco_cfg.svh"

module aco_top
  import aco_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [19:0] REG_WDATA_IN,
  output logic      [19:0] REG_RDATA_OUT,
  input  wire logic        CELL_WR_IN,
  input  wire aco_cell_t   CELL_SEL_IN,
  input  wire logic [19:0] CELL_WDATA_IN,
  output logic      [19:0] CELL_RDATA_OUT,
  input  wire aco_fs_t     SAMPLE_RATE_IN,
  input  wire logic [15:0] PLL_TRIM_IN,
  input  wire logic [3:0]  CORE_DIV_IN,
  input  wire logic        DATA_NEED_IN,
  input  wire logic        DATA_STROBE_IN,
  output logic             DATA_ACCEPT_OUT,
  output logic             DATA_DEMAND_N_OUT,
  output logic             PLL_ENABLE_OUT,
  output logic             SYNTH_TICK_OUT,
  output logic             CORE_CLK_EN_OUT,
  output logic             REFERENCE_CLOCK_OUTPUT_OUT,
  output logic      [3:0]  REFERENCE_CLOCK_OUTPUT_HALF_PERIOD_OUT
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [19:0] ctrl_q;
  logic [19:0] ctrl_d;
  logic [19:0] iocfg_q;
  logic [19:0] iocfg_d;
  logic [19:0] outclk_q;
  logic [19:0] outclk_d;
  logic [19:0] reffreq_q;
  logic [19:0] reffreq_d;
  logic [31:0] phase_q;
  logic [31:0] phase_d;
  logic [32:0] phase_sum;
  logic [31:0] nco_base;
  logic [31:0] nco_trim;
  logic [31:0] nco_inc;
  logic        tick_q;
  logic [3:0]  core_cnt_q;
  logic [3:0]  core_cnt_d;
  logic [3:0]  core_div;
  logic        core_en_q;
  logic        core_en_d;
  logic        demand_n_q;
  logic        demand_n_d;
  logic        accept_q;
  logic        accept_d;
  logic        ctrl_wr;
  logic        cell_wr_io;
  logic        cell_wr_oc;
  logic        cell_wr_rf;
  logic        cpu_en;
  logic        codec_en;
  logic        master_mode;
  logic        family_44k;
  aco_scale_t  fs_scale;
  logic        reference_clock_output_q;
  logic        reference_clock_output_en;
  logic        ocfg_bypass;
  logic        ocfg_extra;

  aco_scaler_if sc_if ();

  // ----------------------------------------------------------------------
  // register and cell decode
  // ----------------------------------------------------------------------
  assign ctrl_wr    = REG_WR_IN && (REG_ADDR_IN == `ACO_CTRL_ADDR);
  assign cpu_en     = ctrl_q[`ACO_CTRL_CPU_BIT];
  assign codec_en   = ctrl_q[`ACO_CTRL_CODEC_BIT];
  assign cell_wr_io = CELL_WR_IN && (CELL_SEL_IN == ACO_CELL_IOCFG);
  // clock-out cell locked while the CPU enable bit (ctrl bit 10) is clear
  assign cell_wr_oc = CELL_WR_IN && (CELL_SEL_IN == ACO_CELL_OUTCLK) && cpu_en;
  assign cell_wr_rf = CELL_WR_IN && (CELL_SEL_IN == ACO_CELL_REFFREQ);

  assign ctrl_d    = ctrl_wr    ? REG_WDATA_IN  : ctrl_q;
  assign iocfg_d   = cell_wr_io ? CELL_WDATA_IN : iocfg_q;
  assign outclk_d  = cell_wr_oc ? CELL_WDATA_IN : outclk_q;
  assign reffreq_d = cell_wr_rf ? CELL_WDATA_IN : reffreq_q;

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ctrl_q <= `ACO_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      iocfg_q <= `ACO_CELL_RST;
    end else begin
      iocfg_q <= iocfg_d;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      outclk_q <= `ACO_CELL_RST;
    end else begin
      outclk_q <= outclk_d;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      reffreq_q <= `ACO_REFFREQ_RST;
    end else begin
      reffreq_q <= reffreq_d;
    end
  end

  // ----------------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------------
  logic [19:0] reg_rdata_d;
  logic [19:0] cell_rdata_d;
  logic [19:0] reg_rdata_q;
  logic [19:0] cell_rdata_q;

  assign reg_rdata_d  = (REG_ADDR_IN == `ACO_CTRL_ADDR) ? ctrl_q : 20'h00000;
  assign cell_rdata_d = (CELL_SEL_IN == ACO_CELL_IOCFG)   ? iocfg_q   :
                        (CELL_SEL_IN == ACO_CELL_OUTCLK)  ? outclk_q  :
                        (CELL_SEL_IN == ACO_CELL_REFFREQ) ? reffreq_q : 20'h00000;

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      reg_rdata_q  <= 20'h00000;
      cell_rdata_q <= 20'h00000;
    end else begin
      reg_rdata_q  <= reg_rdata_d;
      cell_rdata_q <= cell_rdata_d;
    end
  end

  assign REG_RDATA_OUT  = reg_rdata_q;
  assign CELL_RDATA_OUT = cell_rdata_q;

  // ----------------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------------
  assign master_mode = iocfg_q[`ACO_IOCFG_MASTER_BIT];

  // ----------------------------------------------------------------------
  // sample rate families
  // ----------------------------------------------------------------------
  always_comb begin
    family_44k = 1'b0;
    fs_scale   = ACO_SCALE_1;
    case (SAMPLE_RATE_IN)
      ACO_FS_48K: begin
        fs_scale = ACO_SCALE_1;
      end
      ACO_FS_44K1: begin
        family_44k = 1'b1;
        fs_scale   = ACO_SCALE_1;
      end
      ACO_FS_32K: begin
        fs_scale = ACO_SCALE_1;
      end
      ACO_FS_24K: begin
        fs_scale = ACO_SCALE_2;
      end
      ACO_FS_22K05: begin
        family_44k = 1'b1;
        fs_scale   = ACO_SCALE_2;
      end
      ACO_FS_16K: begin
        fs_scale = ACO_SCALE_2;
      end
      ACO_FS_12K: begin
        fs_scale = ACO_SCALE_4;
      end
      ACO_FS_11K025: begin
        family_44k = 1'b1;
        fs_scale   = ACO_SCALE_4;
      end
      ACO_FS_8K: begin
        fs_scale = ACO_SCALE_4;
      end
      default: begin
        family_44k = 1'b0;
        fs_scale   = ACO_SCALE_1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // clock synthesizer
  // ----------------------------------------------------------------------
  // phase accumulator ticks once per synthesizer half period
  assign nco_base  = family_44k ? `ACO_NCO_22M5792 : `ACO_NCO_24M576;
  assign nco_trim  = {{16{PLL_TRIM_IN[15]}}, PLL_TRIM_IN};
  assign nco_inc   = master_mode ? nco_base : (nco_base + nco_trim);
  assign phase_sum = {1'b0, phase_q} + {1'b0, nco_inc};
  assign phase_d   = phase_sum[31:0];

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      phase_q <= 32'h00000000;
      tick_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      tick_q  <= phase_sum[32];
    end
  end

  assign SYNTH_TICK_OUT = tick_q;
  assign PLL_ENABLE_OUT = ~master_mode;

  // ----------------------------------------------------------------------
  // core clock divider
  // ----------------------------------------------------------------------
  assign core_div   = (CORE_DIV_IN == 4'h0) ? `ACO_CORE_DIV_RST : CORE_DIV_IN;
  assign core_en_d  = tick_q && (core_cnt_q >= (core_div - 4'h1));
  assign core_cnt_d = !tick_q ? core_cnt_q :
                      (core_en_d ? 4'h0 : core_cnt_q + 4'h1);

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      core_cnt_q <= 4'h0;
      core_en_q  <= 1'b0;
    end else begin
      core_cnt_q <= core_cnt_d;
      core_en_q  <= core_en_d;
    end
  end

  assign CORE_CLK_EN_OUT = core_en_q;

  // ----------------------------------------------------------------------
  // data demand
  // ----------------------------------------------------------------------
  assign demand_n_d = ~(master_mode && DATA_NEED_IN);
  assign accept_d   = DATA_STROBE_IN && (!master_mode || !demand_n_q);

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      demand_n_q <= 1'b1;
      accept_q   <= 1'b0;
    end else begin
      demand_n_q <= demand_n_d;
      accept_q   <= accept_d;
    end
  end

  assign DATA_DEMAND_N_OUT = demand_n_q;
  assign DATA_ACCEPT_OUT   = accept_q;

  // ----------------------------------------------------------------------
  // reference clock output
  // ----------------------------------------------------------------------
  assign reference_clock_output_en         = cpu_en || codec_en;
  assign ocfg_bypass     = outclk_q[`ACO_OCFG_BYPASS_BIT];
  assign ocfg_extra      = outclk_q[`ACO_OCFG_EXTRA_BIT];
  assign sc_if.edge_tick = tick_q;
  assign sc_if.enable    = reference_clock_output_en;
  assign sc_if.bypass    = ocfg_bypass;
  assign sc_if.extra     = ocfg_extra;
  assign sc_if.scale     = fs_scale;

  aco_scaler u_scaler (
    .clk_in  (CLOCK_IN),
    .nrst_in (NRST_IN),
    .sc      (sc_if.scaler)
  );

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      reference_clock_output_q <= 1'b0;
    end else begin
      reference_clock_output_q <= sc_if.clk_level;
    end
  end

  assign REFERENCE_CLOCK_OUTPUT_OUT = reference_clock_output_q;
  assign REFERENCE_CLOCK_OUTPUT_HALF_PERIOD_OUT       = sc_if.half_period;

endmodule

`default_nettype wire

// [aco_cfg.svh]
`ifndef ACO_CFG_SVH
`define ACO_CFG_SVH

// ----------------------------------------------------------------------
// register and cell layout
// ----------------------------------------------------------------------
`define ACO_CTRL_ADDR        8'h6A
`define ACO_CTRL_RST         20'h00000
`define ACO_CTRL_CODEC_BIT   11
`define ACO_CTRL_CPU_BIT     10
`define ACO_IOCFG_MASTER_BIT 1
`define ACO_OCFG_EXTRA_BIT   17
`define ACO_OCFG_BYPASS_BIT  8
`define ACO_CELL_RST         20'h00000
`define ACO_REFFREQ_RST      20'h04800

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ACO_SYS_CLK_KHZ      100000
`define ACO_NCO_24M576       32'h7DD44135
`define ACO_NCO_22M5792      32'h739B16A4
`define ACO_CORE_DIV_RST     4'h1

`endif

// [aco_pkg.sv]
package aco_pkg;

  typedef enum logic [3:0] {
    ACO_FS_48K,
    ACO_FS_44K1,
    ACO_FS_32K,
    ACO_FS_24K,
    ACO_FS_22K05,
    ACO_FS_16K,
    ACO_FS_12K,
    ACO_FS_11K025,
    ACO_FS_8K
  } aco_fs_t;

  typedef enum logic [1:0] {
    ACO_CELL_IOCFG,
    ACO_CELL_OUTCLK,
    ACO_CELL_REFFREQ
  } aco_cell_t;

  typedef enum logic [1:0] {
    ACO_SCALE_1,
    ACO_SCALE_2,
    ACO_SCALE_4
  } aco_scale_t;

endpackage

// [aco_scaler_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface aco_scaler_if;
  import aco_pkg::*;

  logic       edge_tick;
  logic       enable;
  logic       bypass;
  logic       extra;
  aco_scale_t scale;
  logic       clk_level;
  logic [3:0] half_period;

  modport ctrl (
    output edge_tick,
    output enable,
    output bypass,
    output extra,
    output scale,
    input  clk_level,
    input  half_period
  );

  modport scaler (
    input  edge_tick,
    input  enable,
    input  bypass,
    input  extra,
    input  scale,
    output clk_level,
    output half_period
  );
endinterface

`default_nettype wire

// [aco_scaler.sv]
`timescale 1ns/1ps
`default_nettype none

module aco_scaler
  import aco_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  aco_scaler_if.scaler sc
);

  // ----------------------------------------------------------------------
  // divisor selection
  // ----------------------------------------------------------------------
  logic [3:0] base_div;
  logic [3:0] target_div;
  logic [3:0] cnt_q;
  logic [3:0] half_q;
  logic       lvl_q;
  logic       at_end;

  assign base_div   = (sc.scale == ACO_SCALE_4) ? 4'h4 :
                      (sc.scale == ACO_SCALE_2) ? 4'h2 : 4'h1;
  assign target_div = sc.bypass ? 4'h1 :
                      (sc.extra ? {base_div[2:0], 1'b0} : base_div);
  assign at_end     = (cnt_q == (half_q - 4'h1));

  // ----------------------------------------------------------------------
  // output divider
  // ----------------------------------------------------------------------
  // new divisor loads only at a falling edge or while disabled, so every period is whole
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q  <= 4'h0;
      lvl_q  <= 1'b0;
      half_q <= 4'h1;
    end else if (!sc.enable) begin
      cnt_q  <= 4'h0;
      lvl_q  <= 1'b0;
      half_q <= target_div;
    end else if (sc.edge_tick) begin
      if (at_end) begin
        cnt_q <= 4'h0;
        lvl_q <= ~lvl_q;
        if (lvl_q) begin
          half_q <= target_div;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  assign sc.clk_level   = lvl_q;
  assign sc.half_period = half_q;

endmodule

`default_nettype wire

// [aco_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module aco_top_monitor (
  input wire logic        CLOCK_IN,
  input wire logic        NRST_IN,
  input wire logic        REG_WR_IN,
  input wire logic [7:0]  REG_ADDR_IN,
  input wire logic [19:0] REG_WDATA_IN,
  input wire logic [19:0] REG_RDATA_OUT,
  input wire logic        DATA_NEED_IN,
  input wire logic        DATA_STROBE_IN,
  input wire logic        DATA_ACCEPT_OUT,
  input wire logic        DATA_DEMAND_N_OUT,
  input wire logic        PLL_ENABLE_OUT,
  input wire logic        SYNTH_TICK_OUT,
  input wire logic        REFERENCE_CLOCK_OUTPUT_OUT,
  input wire logic [3:0]  REFERENCE_CLOCK_OUTPUT_HALF_PERIOD_OUT
);
  // ----
  // port checks
  // ----
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!NRST_IN);
  sequence s_wr6a;
    REG_WR_IN && REG_ADDR_IN == 8'h6A;
  endsequence
  sequence s_off;
    s_wr6a ##0 REG_WDATA_IN[11:10] == 2'h0 ##1 !REG_WR_IN [*4];
  endsequence
  property p_reg_rd;
    s_wr6a ##1 (!REG_WR_IN && REG_ADDR_IN == 8'h6A) |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2);
  endproperty
  property p_unmapped;
    REG_ADDR_IN != 8'h6A |=> REG_RDATA_OUT == 20'h00000;
  endproperty
  property p_demand;
    DATA_NEED_IN && !PLL_ENABLE_OUT ##1 !PLL_ENABLE_OUT |-> !DATA_DEMAND_N_OUT;
  endproperty
  property p_refuse;
    DATA_STROBE_IN && !PLL_ENABLE_OUT && DATA_DEMAND_N_OUT |=> !DATA_ACCEPT_OUT;
  endproperty
  property p_slave;
    DATA_STROBE_IN && PLL_ENABLE_OUT |=> DATA_ACCEPT_OUT;
  endproperty
  property p_off;
    s_off |-> !REFERENCE_CLOCK_OUTPUT_OUT;
  endproperty
  property p_half;
    REFERENCE_CLOCK_OUTPUT_HALF_PERIOD_OUT inside {4'h1, 4'h2, 4'h4, 4'h8};
  endproperty
  property p_tick;
    SYNTH_TICK_OUT |=> !SYNTH_TICK_OUT;
  endproperty
  property p_div_switch;
    $changed(REFERENCE_CLOCK_OUTPUT_HALF_PERIOD_OUT) |=> !REFERENCE_CLOCK_OUTPUT_OUT;
  endproperty
  a_reg_rd: assert property (p_reg_rd) else $error("control readback wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_demand: assert property (p_demand) else $error("demand missing");
  a_refuse: assert property (p_refuse) else $error("unrequested data taken");
  a_slave: assert property (p_slave) else $error("slave data dropped");
  a_off: assert property (p_off) else $error("clock out while disabled");
  a_half: assert property (p_half) else $error("bad divisor");
  a_tick: assert property (p_tick) else $error("tick too fast");
  a_div_switch: assert property (p_div_switch) else $error("divisor moved mid period");
endmodule
bind aco_top aco_top_monitor u_mon (.CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN),
  .REG_WR_IN(REG_WR_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .DATA_NEED_IN(DATA_NEED_IN),
  .DATA_STROBE_IN(DATA_STROBE_IN), .DATA_ACCEPT_OUT(DATA_ACCEPT_OUT),
  .DATA_DEMAND_N_OUT(DATA_DEMAND_N_OUT), .PLL_ENABLE_OUT(PLL_ENABLE_OUT),
  .SYNTH_TICK_OUT(SYNTH_TICK_OUT), .REFERENCE_CLOCK_OUTPUT_OUT(REFERENCE_CLOCK_OUTPUT_OUT),
  .REFERENCE_CLOCK_OUTPUT_HALF_PERIOD_OUT(REFERENCE_CLOCK_OUTPUT_HALF_PERIOD_OUT));
`default_nettype wire

// [aco_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module aco_src_model (
  input  wire logic clk_in,
  input  wire logic go_in,
  input  wire logic rogue_in,
  input  wire logic demand_n_in,
  input  wire logic pll_en_in,
  output var logic  strobe_out
);
  // slave: send freely; master: only on demand unless told to misbehave
  wire logic send = go_in && (rogue_in || pll_en_in || !demand_n_in);
  initial strobe_out = 1'h0;
  always @(posedge clk_in) begin
    strobe_out <= #1 send;
  end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "aco_cfg.svh"
module tb;
  import aco_pkg::*;
  logic        clk, nrst, reg_wr, cell_wr, need, go, rogue, want, strobe;
  logic        accept, dem_n, pll, tick, cen, refo;
  logic [7:0]  addr;
  logic [19:0] wdata, cdata, rdata, crdata, r, g;
  logic [15:0] trim;
  logic [3:0]  cdiv, half;
  aco_cell_t   sel;
  aco_fs_t     fs;
  int          mismatches, n_tests, meas, seed, n, k, d;
  int          kq[$];
  logic [19:0] vq[$];
  string       nm[8] = '{"reg", "cell", "half", "pll", "demand_n", "accept", "meas", "refclk"};
  aco_top dut (.CLOCK_IN(clk), .NRST_IN(nrst), .REG_WR_IN(reg_wr), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .CELL_WR_IN(cell_wr), .CELL_SEL_IN(sel),
    .CELL_WDATA_IN(cdata), .CELL_RDATA_OUT(crdata), .SAMPLE_RATE_IN(fs), .PLL_TRIM_IN(trim),
    .CORE_DIV_IN(cdiv), .DATA_NEED_IN(need), .DATA_STROBE_IN(strobe),
    .DATA_ACCEPT_OUT(accept), .DATA_DEMAND_N_OUT(dem_n), .PLL_ENABLE_OUT(pll),
    .SYNTH_TICK_OUT(tick), .CORE_CLK_EN_OUT(cen), .REFERENCE_CLOCK_OUTPUT_OUT(refo),
    .REFERENCE_CLOCK_OUTPUT_HALF_PERIOD_OUT(half));
  aco_src_model src (.clk_in(clk), .go_in(go), .rogue_in(rogue), .demand_n_in(dem_n),
    .pll_en_in(pll), .strobe_out(strobe));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ----
  // drivers and result queue
  // ----
  task automatic step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic note(input int k, input logic [19:0] v);
    kq.push_back(k);
    vq.push_back(v);
    want = 1'h1;
    @(negedge clk);
    #1 want = 1'h0;
    step();
  endtask
  task automatic check(input int k, input logic [19:0] e, input logic [19:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm[k], e, s);
    end
  endtask
  always @(negedge clk) begin
    if (want === 1'h1) begin
      case (kq[0])
        0: g = rdata;
        1: g = crdata;
        2: g = {16'h0, half};
        3: g = {19'h0, pll};
        4: g = {19'h0, dem_n};
        5: g = {19'h0, accept};
        6: g = meas[19:0];
        default: g = {19'h0, refo};
      endcase
      check(kq.pop_front(), vq.pop_front(), g);
    end
  end
  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    addr = a;
    wdata = d;
    reg_wr = 1'h1;
    step();
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [19:0] e);
    addr = a;
    step();
    note(0, e);
  endtask
  task automatic cw(input aco_cell_t s, input logic [19:0] d);
    sel = s;
    cdata = d;
    cell_wr = 1'h1;
    step();
    cell_wr = 1'h0;
  endtask
  task automatic cr(input aco_cell_t s, input logic [19:0] e);
    sel = s;
    step();
    note(1, e);
  endtask
  task automatic pulse();
    go = 1'h1;
    step();
    go = 1'h0;
    step();
  endtask
  // ticks seen while the clock output is high
  task automatic meas_half();
    int w;
    meas = 0;
    w = 0;
    while (refo !== 1'h0 && w < 200) begin
      step();
      w++;
    end
    while (refo !== 1'h1 && w < 200) begin
      step();
      w++;
    end
    while (refo === 1'h1 && w < 200) begin
      meas += tick;
      step();
      w++;
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // about fifteen times the expected run
  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end
  initial begin
    seed = 32'h57cc;
    {nrst, reg_wr, cell_wr, need, go, rogue, want} = 7'h00;
    addr = 8'h6A;
    wdata = 20'h00000;
    cdata = 20'h00000;
    sel = ACO_CELL_IOCFG;
    fs = ACO_FS_48K;
    trim = 16'h0000;
    cdiv = 4'h1;
    step(8);
    nrst = 1'h1;
    rd(8'h6A, 20'h00000);
    note(3, 20'h00001);
    note(4, 20'h00001);
    note(2, 20'h00001);
    cr(ACO_CELL_REFFREQ, `ACO_REFFREQ_RST);
    $display("test reset done");
    r = 20'($random(seed));
    wr(8'h6A, r);
    rd(8'h6A, r);
    wr(8'h6B, ~r);
    rd(8'h6B, 20'h00000);
    rd(8'h6A, r);
    cw(ACO_CELL_REFFREQ, 20'h03E80);
    cr(ACO_CELL_REFFREQ, 20'h03E80);
    wr(8'h6A, 20'h00000);
    cw(ACO_CELL_OUTCLK, 20'h20100);
    cr(ACO_CELL_OUTCLK, 20'h00000);
    note(7, 20'h00000);
    $display("test registers done");
    wr(8'h6A, 20'h00400);
    for (int f = 0; f < 9; f++) begin
      fs = aco_fs_t'(f);
      trim = 16'($random(seed));
      cdiv = 4'($random(seed));
      for (int c = 0; c < 4; c++) begin
        cw(ACO_CELL_OUTCLK, {2'h0, c[1], 8'h00, c[0], 8'h00});
        n = c[0] ? 1 : ((1 << (f / 3)) << c[1]);
        step(40);
        note(2, n[19:0]);
        meas_half();
        note(6, n[19:0]);
      end
      meas = 0;
      k = 0;
      repeat (500) begin
        meas += tick;
        k += cen;
        step();
      end
      // one core enable per divider count of ticks, give or take one
      d = (cdiv == 4'h0) ? 1 : int'(cdiv);
      n = ((k * d >= meas - d) && (k * d <= meas + d)) ? 1 : 0;
      meas = (meas > 236);
      note(6, {19'h0, f % 3 != 1});
      meas = n;
      note(6, 20'h00001);
    end
    $display("test scaler done");
    wr(8'h6A, 20'h00800);
    cw(ACO_CELL_OUTCLK, 20'h00000);
    cr(ACO_CELL_OUTCLK, 20'h20100);
    step(40);
    meas_half();
    note(6, 20'h00001);
    wr(8'h6A, 20'h00000);
    step(4);
    note(7, 20'h00000);
    $display("test hold done");
    wr(8'h6A, 20'h00400);
    cw(ACO_CELL_IOCFG, 20'h00002);
    note(3, 20'h00000);
    rogue = 1'h1;
    pulse();
    note(5, 20'h00000);
    rogue = 1'h0;
    need = 1'h1;
    step(2);
    note(4, 20'h00000);
    pulse();
    note(5, 20'h00001);
    need = 1'h0;
    cw(ACO_CELL_IOCFG, 20'h00000);
    note(3, 20'h00001);
    pulse();
    note(5, 20'h00001);
    $display("test demand done");
    cw(ACO_CELL_IOCFG, 20'h00002);
    nrst = 1'h0;
    step(2);
    nrst = 1'h1;
    note(3, 20'h00001);
    note(4, 20'h00001);
    cr(ACO_CELL_OUTCLK, 20'h00000);
    rd(8'h6A, 20'h00000);
    note(7, 20'h00000);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
`default_nettype wire
